// ---- src/cic_pkg.sv ----
// Constants, types and helpers of the processor interface control block.
// Assumes one 125 MHz clock and a classic Wishbone slave port.

package cic_pkg;

  localparam int ADR_W = 12;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int LANE_W = 8;

  localparam logic [ADR_W-1:0] CTL_OFS = 12'h000;

  // Secure copy layout.
  localparam int S_EN_G0 = 0;
  localparam int S_EN_G1 = 1;
  localparam int S_FIQ_EN = 3;
  localparam int S_EOI_S = 9;
  localparam int S_EOI_NS = 10;

  // Non-secure copy layout, also the layout without security support.
  localparam int NS_EN_G1 = 0;
  localparam int NS_EOI_NS = 9;

  localparam logic RST_BIT = 1'b0;
  localparam logic [DAT_W-1:0] ZERO_W = 32'h0000_0000;

  // Enable changes travel through a short fixed pipeline.
  localparam int APPLY_NS = 40;
  localparam int CLK_NS = 8;
  localparam int APPLY_CYC = (APPLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int EN_W = 3;
  localparam logic [EN_W-1:0] EN_RST = 3'h0;

  typedef struct packed {
    logic [APPLY_CYC-1:0][EN_W-1:0] stage;
  } cic_dly_state_t;

  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] rdat;
    logic en_g0;
    logic en_g1;
    logic fiq_en;
    logic eoi_s;
    logic eoi_ns;
    logic lock_m;
    logic lock_s;
    logic irq;
    logic fiq;
    logic prio_drop;
    logic deact;
    logic dir_bad;
  } cic_state_t;

  function automatic logic [DAT_W-1:0] cic_merge(
    input logic [DAT_W-1:0] old_w,
    input logic [DAT_W-1:0] new_w,
    input logic [SEL_W-1:0] sel
  );
    logic [DAT_W-1:0] m;
    m = old_w;
    for (int i = 0; i < SEL_W; i++) begin
      if (sel[i]) begin
        m[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return m;
  endfunction

endpackage

// ---- src/cic_apply_dly.sv ----
// Fixed-length pipeline that delays the enable bits before use.
// Assumes the input is a register on the same clock.
`timescale 1ns/1ps
`default_nettype none

module cic_apply_dly (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Enables in and out.
  input wire logic [cic_pkg::EN_W-1:0] d_i,
  output logic [cic_pkg::EN_W-1:0] q_o
);

  cic_pkg::cic_dly_state_t r;
  cic_pkg::cic_dly_state_t nxt;

  always_comb begin
    nxt = r;
    nxt.stage = {r.stage[cic_pkg::APPLY_CYC-2:0], d_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.stage <= {cic_pkg::APPLY_CYC{cic_pkg::EN_RST}};
    end else begin
      r <= nxt;
    end
  end

  assign q_o = r.stage[cic_pkg::APPLY_CYC-1];

endmodule // cic_apply_dly

`default_nettype wire

// ---- src/cic_ctrl.sv ----
// Processor interface control register with signalling and
// end-of-interrupt steering.
// Assumes a classic Wishbone master, a distributor on the same clock
// and an asynchronous lockdown pin.
`timescale 1ns/1ps
`default_nettype none

module cic_ctrl #(
  parameter bit SEC_EXT = 1'h1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cic_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [cic_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [cic_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic wb_sec_i,
  output logic [cic_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Lockdown pin.
  input wire logic cfg_lock_i,
  // Highest pending interrupt from the distributor.
  input wire logic pend_valid_i,
  input wire logic pend_grp_i,
  // End-of-interrupt and deactivate writes.
  input wire logic eoi_wr_i,
  input wire logic dir_wr_i,
  input wire logic req_sec_i,
  input wire logic req_grp_i,
  // Signals to the processor core and to priority logic.
  output logic irq_o,
  output logic fiq_o,
  output logic prio_drop_o,
  output logic deact_o,
  output logic dir_bad_o
);

  cic_pkg::cic_state_t r;
  cic_pkg::cic_state_t nxt;

  logic [cic_pkg::EN_W-1:0] en_raw;
  logic [cic_pkg::EN_W-1:0] en_eff;
  logic eff_g0;
  logic eff_g1;
  logic eff_fiq;

  function automatic logic [cic_pkg::DAT_W-1:0] sec_view(
    input cic_pkg::cic_state_t s
  );
    logic [cic_pkg::DAT_W-1:0] w;
    w = cic_pkg::ZERO_W;
    w[cic_pkg::S_EN_G0] = s.en_g0;
    w[cic_pkg::S_EN_G1] = s.en_g1;
    w[cic_pkg::S_FIQ_EN] = s.fiq_en;
    w[cic_pkg::S_EOI_S] = s.eoi_s;
    w[cic_pkg::S_EOI_NS] = s.eoi_ns;
    return w;
  endfunction

  function automatic logic [cic_pkg::DAT_W-1:0] ns_view(
    input cic_pkg::cic_state_t s
  );
    logic [cic_pkg::DAT_W-1:0] w;
    w = cic_pkg::ZERO_W;
    w[cic_pkg::NS_EN_G1] = s.en_g1;
    w[cic_pkg::NS_EOI_NS] = s.eoi_ns;
    return w;
  endfunction

  // Without security support only the non-secure layout exists.
  function automatic logic use_sec(input logic attr);
    return SEC_EXT & attr;
  endfunction

  always_comb begin
    logic wb_req;
    logic hit;
    logic sec;
    logic eoi_mode;
    logic req_ok;
    logic [cic_pkg::DAT_W-1:0] view;
    logic [cic_pkg::DAT_W-1:0] wr;
    wb_req = 1'h0;
    hit = 1'h0;
    sec = 1'h0;
    eoi_mode = 1'h0;
    req_ok = 1'h0;
    view = cic_pkg::ZERO_W;
    wr = cic_pkg::ZERO_W;
    nxt = r;

    // Lockdown pin passes two flops before any use.
    nxt.lock_m = cfg_lock_i;
    nxt.lock_s = r.lock_m;

    // Bus slave: answer one cycle after the request, then drop.
    wb_req = wb_cyc_i & wb_stb_i & ~r.ack;
    hit = (wb_adr_i == cic_pkg::CTL_OFS);
    sec = use_sec(wb_sec_i);
    nxt.ack = wb_req;
    nxt.rdat = cic_pkg::ZERO_W;

    // Each access reaches only the copy its attribute selects.
    if (sec) begin
      view = sec_view(r);
    end else begin
      view = ns_view(r);
    end

    if (wb_req & hit & ~wb_we_i) begin
      nxt.rdat = view;
    end

    if (wb_req & hit & wb_we_i) begin
      wr = cic_pkg::cic_merge(view, wb_dat_i, wb_sel_i);
      if (sec) begin
        // Secure layout holds both groups and both modes.
        nxt.en_g1 = wr[cic_pkg::S_EN_G1];
        nxt.eoi_ns = wr[cic_pkg::S_EOI_NS];
        if (!r.lock_s) begin
          nxt.en_g0 = wr[cic_pkg::S_EN_G0];
          nxt.fiq_en = wr[cic_pkg::S_FIQ_EN];
          nxt.eoi_s = wr[cic_pkg::S_EOI_S];
        end
      end else begin
        // Reserved bits never reach a flop.
        nxt.en_g1 = wr[cic_pkg::NS_EN_G1];
        nxt.eoi_ns = wr[cic_pkg::NS_EOI_NS];
      end
    end

    // Signalling uses the delayed enables, never the raw register.
    nxt.irq = pend_valid_i &
              ((~pend_grp_i & eff_g0 & ~eff_fiq) |
               (pend_grp_i & eff_g1));
    nxt.fiq = pend_valid_i & ~pend_grp_i & eff_g0 & eff_fiq;

    // End-of-interrupt steering by the security of the request.
    if (use_sec(req_sec_i)) begin
      eoi_mode = r.eoi_s;
      req_ok = 1'h1;
    end else begin
      eoi_mode = r.eoi_ns;
      // With security support, a non-secure request may only retire group 1 interrupts.
      req_ok = req_grp_i | ~SEC_EXT;
    end
    nxt.prio_drop = eoi_wr_i & req_ok;
    nxt.deact = req_ok &
                ((eoi_wr_i & ~eoi_mode) |
                 (dir_wr_i & eoi_mode));
    // Deactivate writes in combined mode are flagged, not acted on.
    nxt.dir_bad = req_ok & dir_wr_i & ~eoi_mode;
  end

  // Without security support the single enable gates every group.
  assign en_raw = SEC_EXT ?
                  {r.fiq_en, r.en_g1, r.en_g0} :
                  {1'h0, r.en_g1, r.en_g1};

  cic_apply_dly u_apply_dly (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(en_raw),
    .q_o(en_eff)
  );

  assign eff_g0 = en_eff[0];
  assign eff_g1 = en_eff[1];
  assign eff_fiq = en_eff[2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.ack <= cic_pkg::RST_BIT;
      r.rdat <= cic_pkg::ZERO_W;
      r.en_g0 <= cic_pkg::RST_BIT;
      r.en_g1 <= cic_pkg::RST_BIT;
      r.fiq_en <= cic_pkg::RST_BIT;
      r.eoi_s <= cic_pkg::RST_BIT;
      r.eoi_ns <= cic_pkg::RST_BIT;
      r.lock_m <= cic_pkg::RST_BIT;
      r.lock_s <= cic_pkg::RST_BIT;
      r.irq <= cic_pkg::RST_BIT;
      r.fiq <= cic_pkg::RST_BIT;
      r.prio_drop <= cic_pkg::RST_BIT;
      r.deact <= cic_pkg::RST_BIT;
      r.dir_bad <= cic_pkg::RST_BIT;
    end else begin
      r <= nxt;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdat;
  assign irq_o = r.irq;
  assign fiq_o = r.fiq;
  assign prio_drop_o = r.prio_drop;
  assign deact_o = r.deact;
  assign dir_bad_o = r.dir_bad;

endmodule // cic_ctrl

`default_nettype wire

// ---- dv/cic_ctrl_props.sv ----
// Concurrent checks on the ports of the interface control block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module cic_ctrl_chk (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus side.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [cic_pkg::DAT_W-1:0] wb_dat_o,
  // Interrupt side.
  input wire logic pend_valid_i,
  input wire logic eoi_wr_i,
  input wire logic dir_wr_i,
  input wire logic req_sec_i,
  input wire logic irq_o,
  input wire logic fiq_o,
  input wire logic prio_drop_o,
  input wire logic deact_o,
  input wire logic dir_bad_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  AST_ACK: assert property (s_req |=> s_ans)
    else $error("bus answer missing or too long");
  AST_DAT: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside answer");
  AST_IRQ: assert property (irq_o || fiq_o |-> $past(pend_valid_i))
    else $error("request without pending input");
  AST_IDLE: assert property (!pend_valid_i |=> !irq_o && !fiq_o)
    else $error("request stays after pending input left");
  AST_ONE: assert property (!(irq_o && fiq_o))
    else $error("both request lines high");
  AST_EOI: assert property (eoi_wr_i && req_sec_i |=> prio_drop_o)
    else $error("secure retire gave no drop");
  AST_DROP: assert property (prio_drop_o |-> $past(eoi_wr_i))
    else $error("drop without retire write");
  AST_DEACT: assert property (deact_o |-> $past(eoi_wr_i || dir_wr_i))
    else $error("deactivate without cause");
  AST_BAD: assert property (dir_bad_o |-> $past(dir_wr_i))
    else $error("bad flag without deactivate write");
endmodule // cic_ctrl_chk

bind cic_ctrl cic_ctrl_chk chk_u (.*);
`default_nettype wire

// ---- dv/cic_core_mdl.sv ----
// Processor core model: takes the request lines and retires interrupts.
// Assumes the bench calls retire from one process at a time.
`timescale 1ns/1ps
`default_nettype none

module cic_core_mdl (
  // Clock and request lines.
  input wire logic clk_i,
  input wire logic irq_i,
  input wire logic fiq_i,
  // Retire writes.
  output logic eoi_wr_o,
  output logic dir_wr_o,
  output logic req_sec_o,
  output logic req_grp_o
);
  initial begin
    eoi_wr_o = 1'b0;
    dir_wr_o = 1'b0;
    req_sec_o = 1'b0;
    req_grp_o = 1'b0;
  end

  // Qualifiers flip once released so stale values are never trusted.
  task automatic retire(input logic d, input logic s, input logic g);
    @(posedge clk_i);
    eoi_wr_o <= !d;
    dir_wr_o <= d;
    req_sec_o <= s;
    req_grp_o <= g;
    @(posedge clk_i);
    eoi_wr_o <= 1'b0;
    dir_wr_o <= 1'b0;
    req_sec_o <= !s;
    req_grp_o <= !g;
  endtask
endmodule // cic_core_mdl

`default_nettype wire

// ---- dv/tb.sv ----
// Bench for the interface control block, banked and single-copy builds.
// Assumes the core model drives the retire inputs.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_sec_i, cfg_lock_i;
  logic pend_valid_i, pend_grp_i, eoi_wr_i, dir_wr_i, req_sec_i, req_grp_i;
  logic wb_ack_o, irq_o, fiq_o, prio_drop_o, deact_o, dir_bad_o;
  logic [cic_pkg::ADR_W-1:0] wb_adr_i;
  logic [cic_pkg::SEL_W-1:0] wb_sel_i;
  logic [cic_pkg::DAT_W-1:0] wb_dat_i, wb_dat_o, q, dat1, q1;
  logic irq1, fiq1, drop1, deact1, bad1;
  int error_cnt, check_count, cyc_n;

  cic_ctrl dut_u (.*);
  cic_core_mdl core_u (.clk_i(clk_i), .irq_i(irq_o), .fiq_i(fiq_o),
    .eoi_wr_o(eoi_wr_i), .dir_wr_o(dir_wr_i), .req_sec_o(req_sec_i),
    .req_grp_o(req_grp_i));
  // Single-copy build shares every input with the banked one.
  cic_ctrl #(.SEC_EXT(1'h0)) dut1_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_sec_i(wb_sec_i), .wb_dat_o(dat1), .wb_ack_o(),
    .cfg_lock_i(cfg_lock_i), .pend_valid_i(pend_valid_i),
    .pend_grp_i(pend_grp_i), .eoi_wr_i(eoi_wr_i), .dir_wr_i(dir_wr_i),
    .req_sec_i(req_sec_i), .req_grp_i(req_grp_i), .irq_o(irq1),
    .fiq_o(fiq1), .prio_drop_o(drop1), .deact_o(deact1),
    .dir_bad_o(bad1));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic acc(input logic we, s, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] sl);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sec_i} <= {2'b11, we, s};
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sl;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    q1 = dat1;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic ret(input logic d, s, g, input logic [2:0] e, e1);
    core_u.retire(d, s, g);
    #1 chk("retire", {prio_drop_o, deact_o, dir_bad_o}, e);
    chk("retire1", {drop1, deact1, bad1}, e1);
  endtask

  // Pending inputs change only on a rising edge, never mid-cycle.
  task automatic req(input logic g, input logic [1:0] e, e1);
    @(posedge clk_i);
    pend_valid_i <= 1'h1;
    pend_grp_i <= g;
    repeat (3) @(posedge clk_i);
    #1 chk("req", {irq_o, fiq_o}, e);
    chk("req1", {irq1, fiq1}, e1);
  endtask

  initial begin
    {rst_i, cyc_n, error_cnt, check_count} = '0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sec_i, cfg_lock_i} = '0;
    {pend_valid_i, pend_grp_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(0, 1, 12'h000, 32'h0, 4'hf); chk("s_rst", q, 32'h0);
    chk("s_rst1", q1, 32'h0);
    acc(0, 0, 12'h000, 32'h0, 4'hf); chk("ns_rst", q, 32'h0);
    acc(1, 1, 12'h000, '1, 4'h2);
    acc(0, 1, 12'h000, 32'h0, 4'hf); chk("lane", q, 32'h600);
    chk("lane1", q1, 32'h200);
    acc(1, 1, 12'h000, '1, 4'hf);
    acc(0, 1, 12'h000, 32'h0, 4'hf); chk("s_all", q, 32'h60b);
    chk("s_all1", q1, 32'h201);
    acc(0, 1, 12'h004, 32'h0, 4'hf); chk("unmap", q, 32'h0);
    chk("unmap1", q1, 32'h0);
    repeat (6) @(posedge clk_i);
    req(0, 2'h1, 2'h2);
    req(1, 2'h2, 2'h2);
    acc(1, 1, 12'h000, 32'h0, 4'hf);
    #1 chk("delay", irq_o, 1'h1);
    chk("delay1", irq1, 1'h1);
    repeat (8) @(posedge clk_i);
    #1 chk("off", irq_o, 1'h0);
    chk("off1", irq1, 1'h0);
    acc(1, 0, 12'h000, '1, 4'hf);
    acc(0, 0, 12'h000, 32'h0, 4'hf); chk("ns_all", q, 32'h201);
    chk("ns_all1", q1, 32'h201);
    repeat (6) @(posedge clk_i);
    req(1, 2'h2, 2'h2);
    req(0, 2'h0, 2'h2);
    ret(0, 1, 0, 3'h6, 3'h4);
    ret(1, 1, 0, 3'h1, 3'h2);
    ret(0, 0, 1, 3'h4, 3'h4);
    ret(1, 0, 1, 3'h2, 3'h2);
    ret(0, 0, 0, 3'h0, 3'h4);
    @(posedge clk_i) cfg_lock_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    acc(1, 1, 12'h000, '1, 4'hf);
    acc(0, 1, 12'h000, 32'h0, 4'hf); chk("lock", q, 32'h402);
    chk("lock1", q1, 32'h201);
    stop_test();
  end
endmodule // tb

`default_nettype wire
